// File: verilog/modbus_dispatch_defines.svh
// Purpose: Constants of the Modbus function dispatcher.
// Assumes: Included by its bare name wherever codes are needed.
// Notes: Function, sub-function and exception codes are protocol values.
// What this block does
// - Functions 0x03 and 0x04 alike read consecutive 16-bit registers.
// - Function 0x06 stores one value into the addressed register.
// - Function 0x10 writes consecutive registers from the address.
// - Function 0x16 modifies one register with an AND and OR mask.
// - Function 0x17 writes its registers first, then reads and returns data.
// - Function 0x08 is decoded further by its sub-function code.
// - Diagnostic 0x00 echoes the request data unchanged.
// - Diagnostic 0x0A zeroes all five communication counters together.
// - Every bus message is counted; diagnostic 0x0B returns the count.
// - Every CRC error is counted; diagnostic 0x0C returns the count.
// - Every exception reply sent is counted; diagnostic 0x0D returns it.
// - A slave message counter is read by 0x0E and cleared by 0x0A.
// - Function 11 returns successful message count, never counting itself.
// - Function 0x2B/0x0E returns selected identification strings.
// - Function 17 replies identification code, run status, then text.
// - Run status is 0xFF normally and 0x00 in bootloader mode.
// - Run text: product, input variant, hardware and firmware versions.
// - The text ends with one zero byte right after its last character.
// - In bootloader mode the text gives the bootloader version instead.
// - The device replies only to a query from the master.
// - Holding and input reads share one store; writes use holding space.
`ifndef MODBUS_DISPATCH_DEFINES_SVH
`define MODBUS_DISPATCH_DEFINES_SVH
`define FC_RD_HOLD 8'h03
`define FC_RD_INPUT 8'h04
`define FC_WR_ONE 8'h06
`define FC_DIAG 8'h08
`define FC_EVT_CNT 8'h0b
`define FC_WR_MULTI 8'h10
`define FC_SLAVE_ID 8'h11
`define FC_MASK_WR 8'h16
`define FC_RD_WR 8'h17
`define FC_ENCAP 8'h2b
`define MEI_DEV_ID 8'h0e
`define SUB_ECHO 16'h0000
`define SUB_CLEAR 16'h000a
`define SUB_BUS_MSG 16'h000b
`define SUB_BUS_ERR 16'h000c
`define SUB_BUS_EXC 16'h000d
`define SUB_SLV_MSG 16'h000e
`define EXC_FLAG 8'h80
`define EXC_FUNC 8'h01
`define EXC_ADDR 8'h02
`define EXC_VALUE 8'h03
`define ST_RUN 8'hff
`define ST_BOOT 8'h00
`define DEV_CONFORMITY 8'h83
`define OBJ_COUNT 8'h03
`define OBJ_LEN 8'h08
`define MAX_RD_QTY 16'h007d
`define MAX_WR_QTY 16'h007b
`define MAX_RW_WR_QTY 16'h0079
`define TXT_W 256
`endif

// File: verilog/modbus_disp_pkg.sv
// Purpose: Types shared by the dispatcher and its register store.
// Assumes: Nothing beyond the constants header.
// Notes: State codes are written out.
package modbus_disp_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [15:0] word_t;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_RECV = 3'b001,
    S_EXEC = 3'b010,
    S_WRITE = 3'b011,
    S_TX = 3'b100
  } disp_state_t;
endpackage

// File: verilog/reg_store.sv
// Purpose: Word store behind both holding and input register spaces.
// Assumes: One write port, one combinational read port, same clock.
// Notes: Contents are not reset; software loads them.
module reg_store #(
  parameter int AW = 8
) (
  input wire logic sys_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire modbus_disp_pkg::word_t wr_data,
  input wire logic [AW-1:0] rd_addr,
  output modbus_disp_pkg::word_t rd_data
);
  import modbus_disp_pkg::*;
  word_t mem [2**AW];

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem[rd_addr];
endmodule // reg_store

// File: verilog/modbus_function_dispatcher.sv
// Purpose: Modbus function-code interpreter for the meter slave.
// Assumes: Transport on sys_clk hands over PDU bytes of good frames.
// Notes: One request at a time; reply leaves on a valid/ready port.
`include "modbus_dispatch_defines.svh"
module modbus_function_dispatcher #(
  parameter int REG_AW = 8,
  parameter int BUF_DEPTH = 256,
  parameter logic [7:0] ID_CODE = 8'h5a, // Arbitrary value
  parameter logic [7:0] RUN_LEN = 8'h14,
  parameter logic [`TXT_W-1:0] RUN_TXT = "METER-MA HW1.0 FW1.0",
  parameter logic [7:0] BOOT_LEN = 8'h0e,
  parameter logic [`TXT_W-1:0] BOOT_TXT = "METER BOOT 1.0",
  parameter logic [`TXT_W-1:0] OBJ0_TXT = "NOVENDOR",
  parameter logic [`TXT_W-1:0] OBJ1_TXT = "METER-MA",
  parameter logic [`TXT_W-1:0] OBJ2_TXT = "FW  1.00"
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic rx_start,
  input wire logic rx_valid,
  input wire modbus_disp_pkg::byte_t rx_byte,
  input wire logic rx_end,
  input wire logic bus_msg,
  input wire logic crc_err,
  input wire logic boot_mode,
  input wire logic tx_ready,
  output logic tx_valid,
  output modbus_disp_pkg::byte_t tx_byte,
  output logic tx_last
);
  import modbus_disp_pkg::*;

  localparam logic [16:0] REG_DEPTH = 17'(2**REG_AW);

  logic [1:0] rst_pipe;
  logic sync_rst_n;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!sync_rst_n);

  disp_state_t state;
  byte_t rq [BUF_DEPTH];
  logic [8:0] rq_len;
  logic ovf;
  byte_t fc;
  word_t w1, w2, w3, w4;
  byte_t exc, exc_q, rlen, tx_len, need, tidx, rb, tw;
  logic [6:0] widx;
  word_t wcount;
  logic boot_q;
  logic txgo, clr, wr_en;
  word_t wr_data, rd_data, ra, wa, diag_cnt;
  word_t bus_cnt, err_cnt, exc_cnt, slv_cnt, evt_cnt;

  function automatic word_t wd(int i);
    return {rq[i], rq[i+1]};
  endfunction

  function automatic logic rng_bad(word_t a, word_t q);
    return ({1'b0, a} + {1'b0, q}) > REG_DEPTH;
  endfunction

  function automatic logic qty_bad(word_t q, word_t mx);
    return (q == 16'h0000) || (q > mx);
  endfunction

  function automatic byte_t char_at(logic [`TXT_W-1:0] s, byte_t len,
                                    byte_t i);
    return s[(int'(len) - 1 - int'(i)) * 8 +: 8];
  endfunction

  function automatic word_t bump(word_t c, logic zero, logic inc);
    return (zero ? 16'h0000 : c) + {15'h0000, inc};
  endfunction

  // Reset release through two stages
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign sync_rst_n = rst_pipe[1];

  assign fc = rq[0];
  assign w1 = wd(1);
  assign w2 = wd(3);
  assign w3 = wd(5);
  assign w4 = wd(7);

  // Request capture
  always_ff @(posedge sys_clk) begin
    if ((state == S_RECV) && rx_valid && !rq_len[8]) begin
      rq[rq_len[7:0]] <= rx_byte;
    end
  end

  always_ff @(posedge sys_clk or negedge sync_rst_n) begin
    if (!sync_rst_n) begin
      rq_len <= 9'h000;
      ovf <= 1'b0;
    end else if (rx_start && ((state == S_IDLE) || (state == S_RECV))) begin
      rq_len <= 9'h000;
      ovf <= 1'b0;
    end else if ((state == S_RECV) && rx_valid) begin
      if (rq_len == 9'(BUF_DEPTH)) begin
        ovf <= 1'b1;
      end else begin
        rq_len <= rq_len + 9'h001;
      end
    end
  end

  // Decode and validation of the captured request
  always_comb begin
    exc = 8'h00;
    rlen = 8'h05;
    need = 8'h01;
    case (fc)
      `FC_RD_HOLD, `FC_RD_INPUT: begin
        need = 8'h05;
        rlen = {w2[6:0], 1'b0} + 8'h02;
        if (qty_bad(w2, `MAX_RD_QTY)) begin
          exc = `EXC_VALUE;
        end else if (rng_bad(w1, w2)) begin
          exc = `EXC_ADDR;
        end
      end
      `FC_WR_ONE, `FC_MASK_WR: begin
        need = (fc == `FC_WR_ONE) ? 8'h05 : 8'h07;
        rlen = need;
        if (rng_bad(w1, 16'h0001)) begin
          exc = `EXC_ADDR;
        end
      end
      `FC_DIAG: begin
        need = 8'h05;
        rlen = (w1 == `SUB_ECHO) ? rq_len[7:0] : 8'h05;
        if ((w1 != `SUB_ECHO) && ((w1 < `SUB_CLEAR) ||
            (w1 > `SUB_SLV_MSG))) begin
          exc = `EXC_FUNC;
        end
      end
      `FC_EVT_CNT: begin
        rlen = 8'h05;
      end
      `FC_WR_MULTI: begin
        need = {w2[6:0], 1'b0} + 8'h06;
        if (qty_bad(w2, `MAX_WR_QTY) || (rq[5] != {w2[6:0], 1'b0})) begin
          exc = `EXC_VALUE;
        end else if (rng_bad(w1, w2)) begin
          exc = `EXC_ADDR;
        end
      end
      `FC_SLAVE_ID: begin
        rlen = (boot_mode ? BOOT_LEN : RUN_LEN) + 8'h05;
      end
      `FC_RD_WR: begin
        need = {w4[6:0], 1'b0} + 8'h0a;
        rlen = {w2[6:0], 1'b0} + 8'h02;
        if (qty_bad(w2, `MAX_RD_QTY) || qty_bad(w4, `MAX_RW_WR_QTY) ||
            (rq[9] != {w4[6:0], 1'b0})) begin
          exc = `EXC_VALUE;
        end else if (rng_bad(w1, w2) || rng_bad(w3, w4)) begin
          exc = `EXC_ADDR;
        end
      end
      `FC_ENCAP: begin
        need = 8'h04;
        rlen = `OBJ_LEN + 8'h09;
        if (rq[1] != `MEI_DEV_ID) begin
          exc = `EXC_FUNC;
        end else if (rq[3] >= `OBJ_COUNT) begin
          exc = `EXC_ADDR;
        end
      end
      default: begin
        exc = `EXC_FUNC;
      end
    endcase
    if ((exc == 8'h00) && (ovf || (rq_len < {1'b0, need}))) begin
      exc = `EXC_VALUE;
    end
    if (exc != 8'h00) begin
      rlen = 8'h02;
    end
  end

  assign clr = (state == S_EXEC) && (exc == 8'h00) && (fc == `FC_DIAG) &&
               (w1 == `SUB_CLEAR);
  assign txgo = (state == S_TX) && (!tx_valid || tx_ready);

  always_comb begin
    case (fc)
      `FC_WR_MULTI: wcount = w2;
      `FC_RD_WR: wcount = w4;
      default: wcount = 16'h0001;
    endcase
  end

  // Sequencer; a reply only ever follows a captured query
  always_ff @(posedge sys_clk or negedge sync_rst_n) begin
    if (!sync_rst_n) begin
      state <= S_IDLE;
      exc_q <= 8'h00;
      tx_len <= 8'h00;
      boot_q <= 1'b0;
      widx <= 7'h00;
    end else begin
      case (state)
        S_IDLE: begin
          if (rx_start) begin
            state <= S_RECV;
          end
        end
        S_RECV: begin
          if (rx_end) begin
            state <= S_EXEC;
          end
        end
        S_EXEC: begin
          exc_q <= exc;
          tx_len <= rlen;
          boot_q <= boot_mode;
          widx <= 7'h00;
          if ((exc == 8'h00) && ((fc == `FC_WR_ONE) ||
              (fc == `FC_WR_MULTI) || (fc == `FC_MASK_WR) ||
              (fc == `FC_RD_WR))) begin
            state <= S_WRITE;
          end else begin
            state <= S_TX;
          end
        end
        S_WRITE: begin
          widx <= widx + 7'h01;
          if ({9'h000, widx} == wcount - 16'h0001) begin
            state <= S_TX;
          end
        end
        S_TX: begin
          if (txgo && (tidx == tx_len)) begin
            state <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // Register writes; the store is shared by both read spaces
  always_comb begin
    case (fc)
      `FC_WR_ONE: begin
        wa = w1;
        wr_data = w2;
      end
      `FC_WR_MULTI: begin
        wa = w1 + {9'h000, widx};
        wr_data = wd(6 + 2 * int'(widx));
      end
      `FC_MASK_WR: begin
        wa = w1;
        wr_data = (rd_data & w2) | (w3 & ~w2);
      end
      default: begin
        wa = w3 + {9'h000, widx};
        wr_data = wd(10 + 2 * int'(widx));
      end
    endcase
  end

  assign wr_en = (state == S_WRITE);
  assign tw = tidx - 8'h02;
  assign ra = (state == S_TX) ? (w1 + {9'h000, tw[7:1]}) : w1;

  reg_store #(
    .AW(REG_AW)
  ) u_store (
    .sys_clk(sys_clk),
    .wr_en(wr_en),
    .wr_addr(wa[REG_AW-1:0]),
    .wr_data(wr_data),
    .rd_addr(ra[REG_AW-1:0]),
    .rd_data(rd_data)
  );

  // Communication counters; a new event beats a same-cycle clear
  always_ff @(posedge sys_clk or negedge sync_rst_n) begin
    if (!sync_rst_n) begin
      bus_cnt <= 16'h0000;
      err_cnt <= 16'h0000;
      exc_cnt <= 16'h0000;
      slv_cnt <= 16'h0000;
      evt_cnt <= 16'h0000;
    end else begin
      bus_cnt <= bump(bus_cnt, clr, bus_msg);
      err_cnt <= bump(err_cnt, clr, crc_err);
      exc_cnt <= bump(exc_cnt, clr,
                      (state == S_EXEC) && (exc != 8'h00));
      slv_cnt <= bump(slv_cnt, clr,
                      (state == S_RECV) && rx_end);
      evt_cnt <= bump(evt_cnt, clr, (state == S_EXEC) &&
                      (exc == 8'h00) && (fc != `FC_EVT_CNT));
    end
  end

  always_comb begin
    case (w1)
      `SUB_BUS_MSG: diag_cnt = bus_cnt;
      `SUB_BUS_ERR: diag_cnt = err_cnt;
      `SUB_BUS_EXC: diag_cnt = exc_cnt;
      default: diag_cnt = slv_cnt;
    endcase
  end

  // Reply byte at position tidx
  always_comb begin
    rb = 8'h00;
    if (exc_q != 8'h00) begin
      rb = (tidx == 8'h00) ? (fc | `EXC_FLAG) : exc_q;
    end else begin
      case (fc)
        `FC_RD_HOLD, `FC_RD_INPUT, `FC_RD_WR: begin
          if (tidx == 8'h00) begin
            rb = fc;
          end else if (tidx == 8'h01) begin
            rb = tx_len - 8'h02;
          end else begin
            rb = tidx[0] ? rd_data[7:0] : rd_data[15:8];
          end
        end
        `FC_DIAG: begin
          if ((tidx < 8'h03) || (w1 == `SUB_ECHO) || (w1 == `SUB_CLEAR)) begin
            rb = rq[tidx];
          end else begin
            rb = (tidx == 8'h03) ? diag_cnt[15:8] : diag_cnt[7:0];
          end
        end
        `FC_EVT_CNT: begin
          case (tidx)
            8'h00: rb = fc;
            8'h03: rb = evt_cnt[15:8];
            8'h04: rb = evt_cnt[7:0];
            default: rb = 8'h00;
          endcase
        end
        `FC_SLAVE_ID: begin
          if (tidx == 8'h00) begin
            rb = fc;
          end else if (tidx == 8'h01) begin
            rb = tx_len - 8'h02;
          end else if (tidx == 8'h02) begin
            rb = ID_CODE;
          end else if (tidx == 8'h03) begin
            rb = boot_q ? `ST_BOOT : `ST_RUN;
          end else if (tidx < tx_len - 8'h01) begin
            rb = boot_q ? char_at(BOOT_TXT, BOOT_LEN, tidx - 8'h04) :
                 char_at(RUN_TXT, RUN_LEN, tidx - 8'h04);
          end else begin
            rb = 8'h00;
          end
        end
        `FC_ENCAP: begin
          case (tidx)
            8'h00: rb = fc;
            8'h01: rb = `MEI_DEV_ID;
            8'h02: rb = rq[2];
            8'h03: rb = `DEV_CONFORMITY;
            8'h04, 8'h05: rb = 8'h00;
            8'h06: rb = 8'h01;
            8'h07: rb = rq[3];
            8'h08: rb = `OBJ_LEN;
            default: begin
              case (rq[3])
                8'h00: rb = char_at(OBJ0_TXT, `OBJ_LEN, tidx - 8'h09);
                8'h01: rb = char_at(OBJ1_TXT, `OBJ_LEN, tidx - 8'h09);
                default: rb = char_at(OBJ2_TXT, `OBJ_LEN, tidx - 8'h09);
              endcase
            end
          endcase
        end
        default: begin
          rb = rq[tidx];
        end
      endcase
    end
  end

  // Reply output stage
  always_ff @(posedge sys_clk or negedge sync_rst_n) begin
    if (!sync_rst_n) begin
      tidx <= 8'h00;
      tx_valid <= 1'b0;
      tx_byte <= 8'h00;
      tx_last <= 1'b0;
    end else if (state == S_EXEC) begin
      tidx <= 8'h00;
    end else if (txgo) begin
      if (tidx < tx_len) begin
        tx_valid <= 1'b1;
        tx_byte <= rb;
        tx_last <= (tidx == tx_len - 8'h01);
        tidx <= tidx + 8'h01;
      end else begin
        tx_valid <= 1'b0;
        tx_last <= 1'b0;
      end
    end
  end

  AST_READ_LEN: assert property ((state == S_EXEC) &&
    (exc == 8'h00) && ((fc == `FC_RD_HOLD) || (fc == `FC_RD_INPUT)) |=>
    (state == S_TX) && (tx_len == {$past(w2[6:0]), 1'b0} + 8'h02))
    else $error("read reply length wrong");
  AST_WR_ONE: assert property ((state == S_WRITE) &&
    (fc == `FC_WR_ONE) |-> (wr_data == w2) ##1 (state == S_TX))
    else $error("single write not done once");
  AST_WR_TWO: assert property ((state == S_EXEC) &&
    (exc == 8'h00) && (fc == `FC_WR_MULTI) && (w2 == 16'h0002) |=>
    (state == S_WRITE) [*2] ##1 (state == S_TX))
    else $error("multi write count wrong");
  AST_MASK: assert property ((state == S_WRITE) &&
    (fc == `FC_MASK_WR) |-> wr_data == ((rd_data & w2) | (w3 & ~w2)))
    else $error("masked value wrong");
  AST_RW_ORDER: assert property ((state == S_EXEC) &&
    (exc == 8'h00) && (fc == `FC_RD_WR) |=> (state == S_WRITE) && !tx_valid)
    else $error("read before write");
  AST_CLEAR: assert property (clr |=> (exc_cnt == 16'h0000) &&
    (slv_cnt == 16'h0000) && (evt_cnt == 16'h0001))
    else $error("counters not cleared");
  AST_BUS_CNT: assert property (bus_msg && !clr |=>
    bus_cnt == $past(bus_cnt) + 16'h0001)
    else $error("bus message not counted");
  AST_CRC_CNT: assert property (crc_err && !clr |=>
    err_cnt == $past(err_cnt) + 16'h0001)
    else $error("crc error not counted");
  AST_EXC_CNT: assert property ((state == S_EXEC) &&
    (exc != 8'h00) |=> (exc_cnt == $past(exc_cnt) + 16'h0001) &&
    (tx_len == 8'h02))
    else $error("exception not counted");
  AST_EVT_SELF: assert property ((state == S_EXEC) &&
    (fc == `FC_EVT_CNT) |=> $stable(evt_cnt))
    else $error("event count counted itself");
  AST_ILLEGAL: assert property ((state == S_EXEC) && !(fc inside {
    `FC_RD_HOLD, `FC_RD_INPUT, `FC_WR_ONE, `FC_DIAG, `FC_EVT_CNT,
    `FC_WR_MULTI, `FC_SLAVE_ID, `FC_MASK_WR, `FC_RD_WR, `FC_ENCAP}) |->
    exc == `EXC_FUNC)
    else $error("unsupported function accepted");
  AST_STATUS: assert property (txgo && (tidx == 8'h03) &&
    (fc == `FC_SLAVE_ID) && (exc_q == 8'h00) |=>
    tx_byte == (boot_q ? `ST_BOOT : `ST_RUN))
    else $error("run status byte wrong");
  AST_TERM: assert property (txgo && (fc == `FC_SLAVE_ID) &&
    (exc_q == 8'h00) && (tidx == tx_len - 8'h01) |=>
    (tx_byte == 8'h00) && tx_last)
    else $error("text not zero terminated");
  AST_ONLY_REPLY: assert property (tx_valid |-> state == S_TX)
    else $error("reply outside a query");

  COV_READ: cover property ((state == S_EXEC) && (exc == 8'h00) &&
    (fc == `FC_RD_HOLD) ##[1:300] (tx_valid && tx_ready && tx_last));
  COV_EXC: cover property ((state == S_EXEC) && (exc == `EXC_FUNC));
  COV_RW: cover property ((state == S_WRITE) && (fc == `FC_RD_WR)
    ##1 (state == S_TX));
  COV_ID: cover property (txgo && (fc == `FC_SLAVE_ID) && boot_q);
endmodule // modbus_function_dispatcher

// File: tb/modbus_master_model.sv
// Purpose: Far-side transport model that takes reply bytes.
// Assumes: One reply at a time; clr empties the capture.
// Notes: In slow mode ready toggles every cycle to stall the reply.
module modbus_master_model (
  input wire logic sys_clk,
  input wire logic slow,
  input wire logic clr,
  input wire logic tx_valid,
  input wire modbus_disp_pkg::byte_t tx_byte,
  input wire logic tx_last,
  output logic tx_ready,
  output modbus_disp_pkg::byte_t rsp [0:31],
  output int cnt,
  output logic done
);
  timeunit 1ns;
  timeprecision 1ps;
  import modbus_disp_pkg::*;

  // Capture only on a handshake; the model never asks on its own
  always @(posedge sys_clk) begin
    if (clr) begin
      cnt <= 0;
      done <= 1'b0;
    end else if (tx_valid && tx_ready) begin
      rsp[cnt[4:0]] <= tx_byte;
      cnt <= cnt + 1;
      if (tx_last) begin
        done <= 1'b1;
      end
    end
    tx_ready <= slow ? (~tx_ready && !clr) : 1'b1;
  end
endmodule // modbus_master_model

// File: tb/test_modbus_function_dispatcher.sv
// Purpose: Self-checking bench of the function dispatcher.
// Assumes: Inputs change 2 ns after the rising edge.
// Notes: Table rows hold request and expected reply, right aligned.
module test_modbus_function_dispatcher;
  timeunit 1ns;
  timeprecision 1ps;
  import modbus_disp_pkg::*;

  typedef struct {
    logic [95:0] rq;
    int rl;
    logic [159:0] ex;
    int pl;
  } row_t;

  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic rx_start = 1'b0;
  logic rx_valid = 1'b0;
  byte_t rx_byte = 8'h00;
  logic rx_end = 1'b0;
  logic bus_msg = 1'b0;
  logic crc_err = 1'b0;
  logic boot_mode = 1'b0;
  logic slow = 1'b0;
  logic clr = 1'b0;
  logic tx_ready;
  logic tx_valid;
  byte_t tx_byte;
  logic tx_last;
  byte_t rsp [0:31];
  int cnt;
  logic done;
  int miscompares = 0;
  int checks_done = 0;
  row_t rows [23];

  always #10 sys_clk = ~sys_clk;

  modbus_function_dispatcher uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .rx_start(rx_start),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_end(rx_end),
    .bus_msg(bus_msg), .crc_err(crc_err), .boot_mode(boot_mode),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .tx_last(tx_last)
  );

  modbus_master_model far (
    .sys_clk(sys_clk), .slow(slow), .clr(clr), .tx_valid(tx_valid),
    .tx_byte(tx_byte), .tx_last(tx_last), .tx_ready(tx_ready),
    .rsp(rsp), .cnt(cnt), .done(done)
  );

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Sends one request and waits, bounded, for the whole reply
  task automatic run(input logic [95:0] rq, input int rl);
    int k;
    @(posedge sys_clk) #2 clr = 1'b1;
    @(posedge sys_clk) #2 clr = 1'b0;
    rx_start = 1'b1;
    @(posedge sys_clk) #2 rx_start = 1'b0;
    for (k = 0; k < rl; k++) begin
      rx_valid = 1'b1;
      rx_byte = rq[8*(rl-1-k) +: 8];
      @(posedge sys_clk) #2;
    end
    rx_valid = 1'b0;
    rx_end = 1'b1;
    @(posedge sys_clk) #2 rx_end = 1'b0;
    for (k = 0; k < 400 && done !== 1'b1; k++) begin
      @(posedge sys_clk) #2;
    end
    if (done !== 1'b1) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, done, 1'b1);
      stop_test();
    end
  endtask

  task automatic chk(input logic [159:0] ex, input int pl);
    int j;
    cmp(16'(cnt), 16'(pl));
    for (j = 0; j < pl && j < cnt; j++) begin
      cmp({8'h00, rsp[j]}, {8'h00, ex[8*(pl-1-j) +: 8]});
    end
  endtask

  initial begin
    rows[0] = '{96'h0600051234, 5, 160'h0600051234, 5};
    rows[1] = '{96'h0300050001, 5, 160'h03021234, 4};
    rows[2] = '{96'h0400050001, 5, 160'h04021234, 4};
    rows[3] = '{96'h16000500f00f0f, 7, 160'h16000500f00f0f, 7};
    rows[4] = '{96'h0300050001, 5, 160'h03020f3f, 4};
    rows[5] = '{96'h100010000204aaaa5555, 10, 160'h1000100002, 5};
    rows[6] = '{96'h17001000020011000102_7777, 12,
                160'h1704aaaa7777, 6};
    rows[7] = '{96'h0800001234, 5, 160'h0800001234, 5};
    rows[8] = '{96'h07, 1, 160'h8701, 2};
    rows[9] = '{96'h0800010000, 5, 160'h8801, 2};
    rows[10] = '{96'h2b0e0401, 4,
                 160'h2b0e0483000001010_84d4554455_22d4d41, 17};
    rows[11] = '{96'h2b0e0403, 4, 160'hab02, 2};
    rows[12] = '{96'h08000a0000, 5, 160'h08000a0000, 5};
    rows[13] = '{96'h0b, 1, 160'h0b00000001, 5};
    rows[14] = '{96'h0b, 1, 160'h0b00000001, 5};
    rows[15] = '{96'h08000b0000, 5, 160'h08000b0003, 5};
    rows[16] = '{96'h08000c0000, 5, 160'h08000c0001, 5};
    rows[17] = '{96'h07, 1, 160'h8701, 2};
    rows[18] = '{96'h08000d0000, 5, 160'h08000d0001, 5};
    rows[19] = '{96'h08000e0000, 5, 160'h08000e0007, 5};
    rows[20] = '{96'h0300000000, 5, 160'h8303, 2};
    rows[21] = '{96'h0300ff0002, 5, 160'h8302, 2};
    rows[22] = '{96'h060005, 3, 160'h8603, 2};
    repeat (4) @(posedge sys_clk);
    cmp({15'h0, tx_valid}, 16'h0000);
    #2 rst_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    for (int i = 0; i < 23; i++) begin
      // Traffic seen on the bus between clear and the counter reads
      if (i == 13) begin
        @(posedge sys_clk) #2 bus_msg = 1'b1;
        crc_err = 1'b1;
        @(posedge sys_clk) #2 crc_err = 1'b0;
        repeat (2) @(posedge sys_clk) #2;
        bus_msg = 1'b0;
      end
      run(rows[i].rq, rows[i].rl);
      chk(rows[i].ex, rows[i].pl);
      $display("row %0d done", i);
    end
    slow = 1'b1;
    run(96'h11, 1);
    cmp(16'(cnt), 16'd25);
    cmp({rsp[1], rsp[2]}, 16'h175a);
    cmp({8'h00, rsp[3]}, {8'h00, `ST_RUN});
    cmp({rsp[10], rsp[24]}, 16'h4d00);
    $display("slave id run done");
    boot_mode = 1'b1;
    run(96'h11, 1);
    cmp(16'(cnt), 16'd19);
    cmp({rsp[1], rsp[3]}, {8'h11, `ST_BOOT});
    cmp({rsp[10], rsp[18]}, 16'h4200);
    $display("slave id boot done");
    // Reset in mid-run must bring the event counter back to zero
    @(posedge sys_clk) #2 rst_n = 1'b0;
    @(posedge sys_clk) #2;
    cmp({15'h0, tx_valid}, 16'h0000);
    rst_n = 1'b1;
    repeat (4) @(posedge sys_clk) #2;
    run(96'h0b, 1);
    chk(160'h0b00000000, 5);
    $display("reset test done");
    stop_test();
  end
endmodule // test_modbus_function_dispatcher
